/* src/pwm_ctl_map.svh */
`ifndef PWM_CTL_MAP_SVH
`define PWM_CTL_MAP_SVH

// register byte offsets
`define CENTER_ALIGN_OFS 12'h000
`define MOD_CTRL_OFS 12'h004

// implemented bits and reset values
`define CENTER_ALIGN_MASK 8'h3f
`define MOD_CTRL_MASK 8'h7c
`define CENTER_ALIGN_RST 8'h00
`define MOD_CTRL_RST 8'h00

// modulator_control field positions
`define JOIN01_BIT 4
`define JOIN23_BIT 5
`define JOIN45_BIT 6
`define WAIT_STOP_BIT 3
`define FREEZE_STOP_BIT 2

`endif

/* src/pwm_ctl_pkg.sv */
package pwm_ctl_pkg;

    typedef enum logic [1:0] {
        SEL_CENTER,
        SEL_CONTROL,
        SEL_NONE
    } reg_sel_t;

    // per-channel bits owned by the rest of the unit
    typedef struct packed {
        logic [5:0] enable;
        logic [5:0] polarity;
        logic [5:0] clock_sel;
    } raw_ctrl_t;

    // effective per-channel controls after joining
    typedef struct packed {
        logic [5:0] enable;
        logic [5:0] polarity;
        logic [5:0] clock_sel;
        logic [5:0] center;
    } chan_ctrl_t;

    // one channel's controls
    typedef struct packed {
        logic enable;
        logic polarity;
        logic clock_sel;
        logic center;
    } bit_ctrl_t;

endpackage : pwm_ctl_pkg

/* src/pwm_prescaler_gate.sv */
`timescale 1ns/100ps

module pwm_prescaler_gate (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // chip mode, same clock domain
    input wire logic wait_mode,
    input wire logic freeze_mode,
    // control bits
    input wire logic wait_stop,
    input wire logic freeze_stop,
    // prescaler input clock enable
    output logic run
);
    import pwm_ctl_pkg::*;

    logic next_run;

    // a clock enable, not a gated clock, keeps one clock tree
    always_comb begin
        next_run = 1'b1;
        if (wait_stop && wait_mode) begin
            next_run = 1'b0;
        end else if (freeze_stop && freeze_mode) begin
            next_run = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b1;
        end else begin
            run <= next_run;
        end
    end

endmodule : pwm_prescaler_gate

/* src/pwm_pair_route.sv */
`timescale 1ns/100ps

module pwm_pair_route (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pair join bit
    input wire logic join_pair,
    // raw controls and waveforms of the pair
    input wire pwm_ctl_pkg::bit_ctrl_t hi_raw,
    input wire pwm_ctl_pkg::bit_ctrl_t lo_raw,
    input wire logic hi_wave,
    input wire logic lo_wave,
    // effective controls and pins
    output pwm_ctl_pkg::bit_ctrl_t hi_eff,
    output pwm_ctl_pkg::bit_ctrl_t lo_eff,
    output logic hi_pin,
    output logic lo_pin
);
    import pwm_ctl_pkg::*;

    bit_ctrl_t next_hi_eff;
    bit_ctrl_t next_lo_eff;
    logic next_hi_pin;
    logic next_lo_pin;

    always_comb begin
        next_lo_eff = lo_raw;
        next_lo_pin = lo_wave & lo_raw.enable;
        if (join_pair) begin
            // high byte counts with the low channel's clock and mode
            next_hi_eff = lo_raw;
            next_hi_eff.enable = 1'b0;
            next_hi_pin = 1'b0;
        end else begin
            next_hi_eff = hi_raw;
            next_hi_pin = hi_wave & hi_raw.enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_eff <= '0;
            lo_eff <= '0;
            hi_pin <= 1'b0;
            lo_pin <= 1'b0;
        end else begin
            hi_eff <= next_hi_eff;
            lo_eff <= next_lo_eff;
            hi_pin <= next_hi_pin;
            lo_pin <= next_lo_pin;
        end
    end

endmodule : pwm_pair_route

/* src/pwm_align_concat_control.sv */
`timescale 1ns/100ps
`include "pwm_ctl_map.svh"

// Notes on behaviour
// - one alignment bit per channel; 1 center aligned, 0 left aligned
// - three join bits each merge an adjacent channel pair into 16 bits
// - with join clear, both channels of the pair run independently
// - bit 6 joins 4/5; channel 4 high byte, output on pin 5
// - bit 5 joins 2/3; channel 2 high byte, output on pin 3
// - bit 4 joins 0/1; channel 0 high byte, output on pin 1
// - joined pair follows the low channel's clock, polarity, enable, alignment
// - wait-stop bit set stops prescaler clock during wait mode
// - freeze-stop bit set stops prescaler clock during freeze mode
// - registers stay accessible in freeze; clock resumes on bit clear or exit
// - both registers readable and writable at any time
// - with 0/1 joined, channel 0 enable ignored and its line off
module pwm_align_concat_control #(
    parameter int ADDR_W = 12,
    parameter int NUM_PAIRS = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // per-channel bits and waveforms from the rest of the unit
    input wire pwm_ctl_pkg::raw_ctrl_t chan_raw,
    input wire logic [5:0] chan_wave,
    // chip mode
    input wire logic wait_mode,
    input wire logic freeze_mode,
    // effective controls and pins
    output pwm_ctl_pkg::chan_ctrl_t chan_eff,
    output logic [2:0] join_state,
    output logic [5:0] modulator_output_port,
    output logic prescaler_clk_run
);
    import pwm_ctl_pkg::*;

    if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
        $error("address width must lie between 3 and 32");
    end
    // join bit positions are fixed for three pairs
    if (NUM_PAIRS != 3) begin : g_bad_pairs
        $error("the join field serves exactly three pairs");
    end

    logic [7:0] center_align_select;
    logic [7:0] modulator_control;
    logic [7:0] next_center_align_select;
    logic [7:0] next_modulator_control;
    logic [31:0] next_prdata;
    reg_sel_t sel;
    logic wr_access;
    logic rd_setup;
    bit_ctrl_t raw_ch [0:5];
    bit_ctrl_t eff_ch [0:5];
    logic [5:0] pin;

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (a == ADDR_W'(`CENTER_ALIGN_OFS)) begin
            s = SEL_CENTER;
        end else if (a == ADDR_W'(`MOD_CTRL_OFS)) begin
            s = SEL_CONTROL;
        end
        return s;
    endfunction : decode

    // zero wait states: every access ends in its first access cycle
    assign sel = decode(paddr);
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (sel == SEL_NONE);

    // no interlock on enables: safe ordering is left to software
    always_comb begin
        next_center_align_select = center_align_select;
        next_modulator_control = modulator_control;
        if (wr_access && sel == SEL_CENTER) begin
            next_center_align_select = pwdata[7:0] & `CENTER_ALIGN_MASK;
        end else if (wr_access && sel == SEL_CONTROL) begin
            next_modulator_control = pwdata[7:0] & `MOD_CTRL_MASK;
        end
    end

    // read data is captured in the setup cycle so it is a flop output
    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            if (sel == SEL_CENTER) begin
                next_prdata = {24'h000000, center_align_select};
            end else if (sel == SEL_CONTROL) begin
                next_prdata = {24'h000000, modulator_control};
            end else begin
                next_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            center_align_select <= `CENTER_ALIGN_RST;
            modulator_control <= `MOD_CTRL_RST;
            prdata <= 32'h00000000;
        end else begin
            center_align_select <= next_center_align_select;
            modulator_control <= next_modulator_control;
            prdata <= next_prdata;
        end
    end

    assign join_state = {modulator_control[`JOIN45_BIT], modulator_control[`JOIN23_BIT],
                         modulator_control[`JOIN01_BIT]};

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            raw_ch[i].enable = chan_raw.enable[i];
            raw_ch[i].polarity = chan_raw.polarity[i];
            raw_ch[i].clock_sel = chan_raw.clock_sel[i];
            raw_ch[i].center = center_align_select[i];
        end
    end

    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        pwm_pair_route u_route (
            .pclk(pclk),
            .presetn(presetn),
            .join_pair(join_state[p]),
            .hi_raw(raw_ch[2*p]),
            .lo_raw(raw_ch[2*p+1]),
            .hi_wave(chan_wave[2*p]),
            .lo_wave(chan_wave[2*p+1]),
            .hi_eff(eff_ch[2*p]),
            .lo_eff(eff_ch[2*p+1]),
            .hi_pin(pin[2*p]),
            .lo_pin(pin[2*p+1])
        );
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            chan_eff.enable[i] = eff_ch[i].enable;
            chan_eff.polarity[i] = eff_ch[i].polarity;
            chan_eff.clock_sel[i] = eff_ch[i].clock_sel;
            chan_eff.center[i] = eff_ch[i].center;
        end
    end

    assign modulator_output_port = pin;

    // register access is never blocked by freeze
    pwm_prescaler_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .wait_mode(wait_mode),
        .freeze_mode(freeze_mode),
        .wait_stop(modulator_control[`WAIT_STOP_BIT]),
        .freeze_stop(modulator_control[`FREEZE_STOP_BIT]),
        .run(prescaler_clk_run)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_center_write: assert property (
        (wr_access && sel == SEL_CENTER) |-> ##2 chan_eff.center[5] == $past(pwdata[5], 2)
            && chan_eff.center[1] == $past(pwdata[1], 2)
    ) else $error("alignment write did not reach channel controls");

    a_reg_readback: assert property (
        (rd_setup && sel == SEL_CONTROL) |=> prdata == {24'h000000, modulator_control}
    ) else $error("control register read returned wrong data");

    a_join_write: assert property (
        (wr_access && sel == SEL_CONTROL) |=> join_state == $past(pwdata[6:4])
    ) else $error("join bits did not take the written value");

    a_unused_zero: assert property (
        center_align_select[7:6] == 2'b00 && modulator_control[7] == 1'b0
            && modulator_control[1:0] == 2'b00
    ) else $error("unused register bits are not zero");

    for (genvar q = 0; q < NUM_PAIRS; q++) begin : g_chk
        a_pair_separate: assert property (
            $past(presetn) && !$past(join_state[q]) |-> chan_eff.enable[2*q] == $past(chan_raw.enable[2*q])
                && modulator_output_port[2*q] == $past(chan_wave[2*q] & chan_raw.enable[2*q])
        ) else $error("unjoined high channel not independent");

        a_low_controls: assert property (
            $past(presetn) && $past(join_state[q]) |-> chan_eff.polarity[2*q] == $past(chan_raw.polarity[2*q+1])
                && chan_eff.clock_sel[2*q] == $past(chan_raw.clock_sel[2*q+1])
                && chan_eff.center[2*q] == $past(center_align_select[2*q+1])
        ) else $error("joined pair not steered by low channel");

        a_hi_ctrl_own: assert property (
            $past(presetn) && !$past(join_state[q]) |-> chan_eff.polarity[2*q] == $past(chan_raw.polarity[2*q])
                && chan_eff.clock_sel[2*q] == $past(chan_raw.clock_sel[2*q])
                && chan_eff.center[2*q] == $past(center_align_select[2*q])
        ) else $error("unjoined high channel controls not its own");

        a_hi_line_off: assert property (
            $past(presetn) && $past(join_state[q]) |-> !chan_eff.enable[2*q] && !modulator_output_port[2*q]
        ) else $error("joined high channel still enabled");

        a_lo_ctrl_own: assert property (
            $past(presetn) |-> chan_eff.enable[2*q+1] == $past(chan_raw.enable[2*q+1])
                && chan_eff.polarity[2*q+1] == $past(chan_raw.polarity[2*q+1])
                && chan_eff.clock_sel[2*q+1] == $past(chan_raw.clock_sel[2*q+1])
                && chan_eff.center[2*q+1] == $past(center_align_select[2*q+1])
        ) else $error("low channel not driven by its own controls");

        a_lo_pin: assert property (
            $past(presetn) |-> modulator_output_port[2*q+1] == $past(chan_wave[2*q+1] & chan_raw.enable[2*q+1])
        ) else $error("low channel pin does not follow its wave and enable");
    end

    a_join45_route: assert property (
        $past(presetn) && $past(join_state[2]) |-> modulator_output_port[4] == 1'b0
            && modulator_output_port[5] == $past(chan_wave[5] & chan_raw.enable[5])
    ) else $error("pair 4/5 joined output not on pin 5");

    a_join23_route: assert property (
        $past(presetn) && $past(join_state[1]) |-> modulator_output_port[2] == 1'b0
            && modulator_output_port[3] == $past(chan_wave[3] & chan_raw.enable[3])
    ) else $error("pair 2/3 joined output not on pin 3");

    a_join01_route: assert property (
        $past(presetn) && $past(join_state[0]) |-> modulator_output_port[0] == 1'b0
            && modulator_output_port[1] == $past(chan_wave[1] & chan_raw.enable[1])
    ) else $error("pair 0/1 joined output not on pin 1");

    a_ch0_disabled: assert property (
        (join_state[0] && chan_raw.enable[0]) |=> !chan_eff.enable[0]
    ) else $error("channel 0 enable acted while joined");

    a_wait_stop: assert property (
        (wait_mode && modulator_control[`WAIT_STOP_BIT]) |=> !prescaler_clk_run
    ) else $error("prescaler clock ran in wait mode with stop set");

    a_wait_run: assert property (
        (wait_mode && !modulator_control[`WAIT_STOP_BIT] && !freeze_mode) |=> prescaler_clk_run
    ) else $error("prescaler clock stopped in wait mode with stop clear");

    a_freeze_stop: assert property (
        (freeze_mode && modulator_control[`FREEZE_STOP_BIT]) |=> !prescaler_clk_run
    ) else $error("prescaler clock ran in freeze mode with stop set");

    a_freeze_resume: assert property (
        (!prescaler_clk_run && !wait_mode && (!freeze_mode || !modulator_control[`FREEZE_STOP_BIT]))
            |=> prescaler_clk_run
    ) else $error("prescaler clock did not resume after freeze");

    a_freeze_access: assert property (
        (freeze_mode && wr_access && sel == SEL_CENTER)
            |=> center_align_select == ($past(pwdata[7:0]) & `CENTER_ALIGN_MASK)
    ) else $error("register write lost during freeze");

    a_center_mask: assert property (
        (wr_access && sel == SEL_CENTER) |=> center_align_select == ($past(pwdata[7:0]) & `CENTER_ALIGN_MASK)
    ) else $error("alignment write not masked to implemented bits");

    a_ctrl_mask: assert property (
        (wr_access && sel == SEL_CONTROL) |=> modulator_control == ($past(pwdata[7:0]) & `MOD_CTRL_MASK)
    ) else $error("control write not masked to implemented bits");

    a_center_readback: assert property (
        (rd_setup && sel == SEL_CENTER) |=> prdata == {24'h000000, center_align_select}
    ) else $error("alignment register read returned wrong data");

    a_read_no_side: assert property (
        rd_setup |=> $stable(center_align_select) && $stable(modulator_control)
    ) else $error("register read changed register contents");

    a_unmapped_quiet: assert property (
        (wr_access && sel == SEL_NONE) |=> $stable(center_align_select) && $stable(modulator_control)
    ) else $error("unmapped write changed a register");

    a_prdata_hold: assert property (
        !rd_setup |=> $stable(prdata)
    ) else $error("read data changed outside a read setup");

    a_ctrl_keeps_center: assert property (
        (wr_access && sel == SEL_CONTROL) |=> $stable(center_align_select)
    ) else $error("control write disturbed alignment bits");

    a_stop_release: assert property (
        (!(wait_mode && modulator_control[`WAIT_STOP_BIT]) && !(freeze_mode && modulator_control[`FREEZE_STOP_BIT]))
            |=> prescaler_clk_run
    ) else $error("prescaler clock held with no stop condition");

    a_mapped_ok: assert property (
        (psel && penable && (paddr == ADDR_W'(`CENTER_ALIGN_OFS) || paddr == ADDR_W'(`MOD_CTRL_OFS)))
            |-> pready && !pslverr
    ) else $error("mapped register access was refused");

endmodule : pwm_align_concat_control

/* bench/pwm_align_concat_control_bench.sv */
`timescale 1ns/100ps
`include "pwm_ctl_map.svh"

module pwm_align_concat_control_bench;
    import pwm_ctl_pkg::*;

    // clock, reset and bus
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    // unit side
    raw_ctrl_t chan_raw;
    chan_ctrl_t chan_eff, e;
    logic [5:0] chan_wave, modulator_output_port;
    logic [2:0] join_state;
    logic wait_mode, freeze_mode, prescaler_clk_run;
    int n_fail, checks, seed;
    logic [31:0] rd, rv;
    logic err;
    logic [7:0] ca, ctl;

    pwm_align_concat_control i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_raw(chan_raw), .chan_wave(chan_wave), .wait_mode(wait_mode),
        .freeze_mode(freeze_mode), .chan_eff(chan_eff), .join_state(join_state),
        .modulator_output_port(modulator_output_port), .prescaler_clk_run(prescaler_clk_run)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict;
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask : check

    // one apb transfer; waits for pready, never assumes a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // outputs are registered; let every edge land before looking
    task automatic settle;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    function automatic chan_ctrl_t exp_eff(raw_ctrl_t r, logic [7:0] c, logic [7:0] t);
        chan_ctrl_t x;
        x.enable = r.enable;
        x.polarity = r.polarity;
        x.clock_sel = r.clock_sel;
        x.center = c[5:0];
        for (int p = 0; p < 3; p++) begin
            if (t[4+p]) begin
                x.enable[2*p] = 1'b0;
                x.polarity[2*p] = r.polarity[2*p+1];
                x.clock_sel[2*p] = r.clock_sel[2*p+1];
                x.center[2*p] = c[2*p+1];
            end
        end
        return x;
    endfunction : exp_eff

    initial begin
        #50000;
        n_fail++;
        give_verdict();
    end

    initial begin
        seed = 89767;
        n_fail = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        chan_raw = '0;
        chan_wave = 6'h00;
        wait_mode = 1'b0;
        freeze_mode = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CENTER_ALIGN_OFS, 32'h0);
        check("center reset", 32'h0, rd);
        check("mapped read err", 32'h0, {31'h0, err});
        check("ready", 32'h1, {31'h0, pready});
        apb(1'b0, `MOD_CTRL_OFS, 32'h0);
        check("control reset", 32'h0, rd);
        apb(1'b1, `CENTER_ALIGN_OFS, 32'hffffffff);
        apb(1'b0, `CENTER_ALIGN_OFS, 32'h0);
        check("center unused bits", 32'h3f, rd);
        apb(1'b1, `MOD_CTRL_OFS, 32'hffffffff);
        apb(1'b0, `MOD_CTRL_OFS, 32'h0);
        check("control unused bits", 32'h7c, rd);
        apb(1'b1, 12'h008, 32'h55);
        check("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped read", 32'h0, rd);
        check("unmapped read err", 32'h1, {31'h0, err});
        // first 32 passes walk every join and stop-bit mix, then free random
        for (int i = 0; i < 48; i++) begin
            @(posedge pclk);
            chan_raw <= '0;
            rv = $random(seed);
            ca = rv[7:0];
            ctl = (i < 32) ? {1'b0, i[2:0], i[4:3], rv[9:8]} : rv[15:8];
            apb(1'b1, `CENTER_ALIGN_OFS, rv);
            apb(1'b1, `MOD_CTRL_OFS, {24'h0, ctl});
            apb(1'b0, `MOD_CTRL_OFS, 32'h0);
            check("control readback", {24'h0, ctl & 8'h7c}, rd);
            apb(1'b0, `CENTER_ALIGN_OFS, 32'h0);
            check("center readback", {24'h0, ca & 8'h3f}, rd);
            rv = $random(seed);
            @(posedge pclk);
            chan_raw <= raw_ctrl_t'(rv[17:0]);
            chan_wave <= rv[23:18];
            wait_mode <= rv[24];
            freeze_mode <= rv[25];
            settle();
            e = exp_eff(raw_ctrl_t'(rv[17:0]), ca, ctl);
            check("effective controls", {8'h0, e}, {8'h0, chan_eff});
            check("pins", {26'h0, rv[23:18] & e.enable}, {26'h0, modulator_output_port});
            check("join state", {29'h0, ctl[6:4]}, {29'h0, join_state});
            check("prescaler run", {31'h0, !((ctl[3] & rv[24]) | (ctl[2] & rv[25]))},
                {31'h0, prescaler_clk_run});
        end
        @(posedge pclk);
        freeze_mode <= 1'b1;
        wait_mode <= 1'b1;
        chan_raw <= '0;
        apb(1'b1, `MOD_CTRL_OFS, 32'h04);
        apb(1'b0, `MOD_CTRL_OFS, 32'h0);
        check("freeze access", 32'h04, rd);
        settle();
        check("freeze held", 32'h0, {31'h0, prescaler_clk_run});
        apb(1'b1, `MOD_CTRL_OFS, 32'h0);
        settle();
        check("freeze bit cleared", 32'h1, {31'h0, prescaler_clk_run});
        apb(1'b1, `MOD_CTRL_OFS, 32'h04);
        @(posedge pclk);
        freeze_mode <= 1'b0;
        settle();
        check("freeze exit", 32'h1, {31'h0, prescaler_clk_run});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MOD_CTRL_OFS, 32'h0);
        check("control after reset", 32'h0, rd);
        give_verdict();
    end
endmodule : pwm_align_concat_control_bench
